// ### core/exc_detect_dispatch.sv
// Exception detect and dispatch for a 32-bit RISC core.
// Assumes a decoder that classifies each completing instruction
// and an APB master on the same clock; no input needs syncing.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "exc_params.svh"

module exc_detect_dispatch (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  exc_pkg::issue_t       issue,
    output logic                  issue_ready,
    output exc_pkg::exc_out_t     exc_event
);

    exc_pkg::state_t   state_r;     // All registered state
    exc_pkg::state_t   state_nxt;   // Its next value
    exc_pkg::cause_t   win;         // Winning instruction cause
    logic [`CTL_W-1:0] ctl;         // Machine state control
    logic              acc;         // Instruction accepted
    logic              mem_op;      // Any data access class
    logic              align_hit;   // Alignment condition
    logic              fpu_class;   // Uses the float unit
    logic              fen_hit;     // Enabled float condition
    logic              fe_eff;      // Float exceptions in force
    logic              decr_fire;   // Decrementer taken now
    logic              decr_wrap;   // Counts down through zero
    logic              mapped;      // APB address decodes
    logic              wr;          // APB write lands
    logic [`FST_W-1:0] st_set;      // Sticky bits raised
    logic [`FST_W-1:0] st_new;      // Sticky bits that change
    logic [31:0]       base;        // Vector base from control

    // Low address bits must be clear for 2**size bytes
    function automatic logic misaligned(input logic [1:0] size, input logic [31:0] ea);
        logic [2:0] mask;
        mask = 3'h7 >> (2'h3 - size);
        return |(ea[2:0] & mask);
    endfunction

    // Handler offset for each cause
    function automatic logic [31:0] vec_off(input exc_pkg::cause_t c);
        case (c)
            exc_pkg::CS_ALIGN:   vec_off = `VOFF_ALIGN;
            exc_pkg::CS_FPU_OFF: vec_off = `VOFF_FPU;
            exc_pkg::CS_EMUL:    vec_off = `VOFF_EMUL;
            exc_pkg::CS_DECR:    vec_off = `VOFF_DECR;
            exc_pkg::CS_SYSCALL: vec_off = `VOFF_SYSCALL;
            default:             vec_off = `VOFF_PROG;
        endcase
    endfunction

    assign ctl  = state_r.ctl;
    assign base = ctl[`CTL_VEC_BASE] ? `VBASE_HIGH : `VBASE_LOW;

    // Decrementer wins the slot only outside serialisation
    assign decr_fire   = state_r.decr_pend & ctl[`CTL_EXT_INT_EN]
                       & (state_r.ser == exc_pkg::ST_RUN);
    // Hold completion during serialisation or a decrementer take
    assign issue_ready = (state_r.ser == exc_pkg::ST_RUN) & ~decr_fire;
    assign acc         = clk_en & issue.valid & issue_ready;

    // APB: no wait states; read data comes from a flop loaded in the setup phase
    assign pready  = psel & penable & clk_en;
    assign mapped  = (paddr == `OFF_CTRL) | (paddr == `OFF_FSTAT) | (paddr == `OFF_DECR)
                   | (paddr == `OFF_FAULT_ADDR) | (paddr == `OFF_SAVED_PC) | (paddr == `OFF_CAUSE);
    assign pslverr = pready & ~mapped;
    assign wr      = pready & pwrite & mapped;
    assign prdata  = state_r.prdata;
    assign exc_event = state_r.exc;

    // Either imprecise mode counts as precise, so any set bit
    assign fe_eff = ctl[`CTL_FEM0] | ctl[`CTL_FEM1];

    // Detection and priority of instruction exceptions
    always_comb begin
        mem_op = (issue.cls == exc_pkg::IC_LOAD_STORE) | (issue.cls == exc_pkg::IC_FLOAT_LS)
               | (issue.cls == exc_pkg::IC_MULTIPLE) | (issue.cls == exc_pkg::IC_RESERVE);
        align_hit = 1'b0;
        // Float load/store needs a word boundary
        if (issue.cls == exc_pkg::IC_FLOAT_LS && issue.ea[1:0] != 2'h0) begin
            align_hit = 1'b1;
        end
        // Cache zero into uncached translated page
        if (issue.cls == exc_pkg::IC_CACHE_ZERO && issue.virt && issue.wt_or_ci) begin
            align_hit = 1'b1;
        end
        // Multiple and reservation forms need a word boundary
        if ((issue.cls == exc_pkg::IC_MULTIPLE || issue.cls == exc_pkg::IC_RESERVE)
            && issue.ea[1:0] != 2'h0) begin
            align_hit = 1'b1;
        end
        // Little-endian mode cannot split misaligned accesses
        if (mem_op && ctl[`CTL_BYTE_ORDER] && misaligned(issue.size, issue.ea)) begin
            align_hit = 1'b1;
        end
        // Multiples are never done little-endian
        if (issue.cls == exc_pkg::IC_MULTIPLE && ctl[`CTL_BYTE_ORDER]) begin
            align_hit = 1'b1;
        end
        fpu_class = (issue.cls == exc_pkg::IC_FLOAT_LS) | (issue.cls == exc_pkg::IC_FLOAT_ARITH);
        fen_hit   = (issue.cls == exc_pkg::IC_FLOAT_ARITH) && |(issue.fp_raised & state_r.fen);
        // Fixed order; later causes are dropped with the instruction
        if (issue.cls == exc_pkg::IC_ILLEGAL || issue.cls == exc_pkg::IC_WIDE_ONLY
            || issue.cls == exc_pkg::IC_OPT_MISSING) begin
            win = exc_pkg::CS_ILLEGAL;
        end else if (ctl[`CTL_USER_MODE] && (issue.cls == exc_pkg::IC_SUPERVISOR
                     || (issue.cls == exc_pkg::IC_BAD_SPECIAL && issue.special_bit0))) begin
            win = exc_pkg::CS_PRIV;
        end else if (fpu_class && !ctl[`CTL_FLOAT_AVAIL]) begin
            win = exc_pkg::CS_FPU_OFF;
        end else if (issue.cls == exc_pkg::IC_EMULATED || fen_hit) begin
            win = exc_pkg::CS_EMUL;
        end else if (align_hit) begin
            win = exc_pkg::CS_ALIGN;
        end else if (issue.cls == exc_pkg::IC_TRAP && issue.trap_hit) begin
            win = exc_pkg::CS_TRAP;
        end else if (issue.cls == exc_pkg::IC_SYSCALL) begin
            win = exc_pkg::CS_SYSCALL;
        end else begin
            win = exc_pkg::CS_NONE;  // Includes optional no-ops
        end
        // Sticky bits only move on a clean float completion
        st_set = (acc && issue.cls == exc_pkg::IC_FLOAT_ARITH && win == exc_pkg::CS_NONE)
               ? issue.fp_raised : `FST_RST;
        st_new = st_set & ~state_r.fsticky;
    end

    assign decr_wrap = (state_r.decr == 32'h00000000) & ~(wr & paddr == `OFF_DECR);

    // Next state; a low clock enable freezes everything
    always_comb begin
        state_nxt = state_r;
        if (clk_en) begin
            state_nxt.exc.take = 1'b0;
            // Register writes
            if (wr && paddr == `OFF_CTRL) begin
                state_nxt.ctl = pwdata[`CTL_W-1:0];
            end
            if (wr && paddr == `OFF_FSTAT) begin
                state_nxt.fen     = pwdata[`FST_EN_LSB +: `FST_W];
                state_nxt.fsticky = pwdata[`FST_STICKY_LSB +: `FST_W];
            end
            // Hardware set wins over a software clear
            state_nxt.fsticky = state_nxt.fsticky | st_set;
            // Decrementer load or count
            if (wr && paddr == `OFF_DECR) begin
                state_nxt.decr = pwdata;
            end else begin
                state_nxt.decr = state_r.decr - 32'h00000001;
            end
            // Repeated wraps collapse into one request; a new wrap beats the clear
            state_nxt.decr_pend = decr_wrap | (state_r.decr_pend & ~decr_fire);
            // Serialisation of sticky updates
            case (state_r.ser)
                exc_pkg::ST_RUN: begin
                    // Only when float exceptions are off and a bit changes
                    if (|st_new && !fe_eff) begin
                        if (|(st_new & (st_new - 5'h01))) begin
                            state_nxt.ser = exc_pkg::ST_FIRST;
                        end else begin
                            state_nxt.ser = exc_pkg::ST_LAST;
                        end
                    end
                end
                exc_pkg::ST_FIRST: state_nxt.ser = exc_pkg::ST_LAST;
                default:           state_nxt.ser = exc_pkg::ST_RUN;
            endcase
            // Dispatch; the decrementer blocks completion in its slot
            if (decr_fire) begin
                state_nxt.exc.take       = 1'b1;
                state_nxt.exc.cause      = exc_pkg::CS_DECR;
                state_nxt.exc.vector     = base | vec_off(exc_pkg::CS_DECR);
                state_nxt.saved_pc_reg   = issue.pc;
                state_nxt.ctl[`CTL_EXT_INT_EN] = 1'b0;
            end else if (acc && win != exc_pkg::CS_NONE) begin
                state_nxt.exc.take     = 1'b1;
                state_nxt.exc.cause    = win;
                state_nxt.exc.vector   = base | vec_off(win);
                state_nxt.saved_pc_reg = issue.pc;
                state_nxt.cause_flags  = {fe_eff, fen_hit & fe_eff};
                if (win == exc_pkg::CS_SYSCALL) begin
                    state_nxt.saved_pc_reg = issue.next_pc;
                end
                if (win == exc_pkg::CS_ALIGN) begin
                    // Multiples report one word past the computed address
                    state_nxt.fault_address_reg = (issue.cls == exc_pkg::IC_MULTIPLE)
                        ? issue.ea + `MULTI_ADDR_BIAS : issue.ea;
                end
            end
            // Read data captured in the setup phase
            if (psel && !penable) begin
                case (paddr)
                    `OFF_CTRL:       state_nxt.prdata = {24'h000000, ctl};
                    `OFF_FSTAT:      state_nxt.prdata = {19'h00000, state_r.fsticky, 3'h0, state_r.fen};
                    `OFF_DECR:       state_nxt.prdata = state_r.decr;
                    `OFF_FAULT_ADDR: state_nxt.prdata = state_r.fault_address_reg;
                    `OFF_SAVED_PC:   state_nxt.prdata = state_r.saved_pc_reg;
                    `OFF_CAUSE:      state_nxt.prdata = {22'h000000, state_r.cause_flags,
                                                         4'h0, state_r.exc.cause};
                    default:         state_nxt.prdata = 32'h00000000;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r                   <= '0;
            state_r.ctl               <= `CTL_RST;
            state_r.decr              <= `DECR_RST;
            state_r.exc.cause         <= exc_pkg::CS_NONE;
            state_r.ser               <= exc_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_multi_align;
        acc && !decr_fire && win == exc_pkg::CS_ALIGN && issue.cls == exc_pkg::IC_MULTIPLE;
    endsequence
    sequence s_syscall;
        acc && !decr_fire && win == exc_pkg::CS_SYSCALL;
    endsequence
    sequence s_ser_start;
        clk_en && state_r.ser == exc_pkg::ST_RUN && |st_new && !fe_eff;
    endsequence

    property p_multi_fault;
        s_multi_align |=> state_r.fault_address_reg == $past(issue.ea) + `MULTI_ADDR_BIAS;
    endproperty
    a_multi_fault: assert property (p_multi_fault) else $error("multiple fault address wrong");

    property p_fp_align;
        (acc && issue.cls == exc_pkg::IC_FLOAT_LS && issue.ea[1:0] != 2'h0 && ctl[`CTL_FLOAT_AVAIL]
         && !decr_fire) |=> state_r.exc.take && state_r.exc.cause == exc_pkg::CS_ALIGN;
    endproperty
    a_fp_align: assert property (p_fp_align) else $error("float misalign not raised");

    property p_prog_vec;
        (state_r.exc.take && (state_r.exc.cause == exc_pkg::CS_TRAP || state_r.exc.cause == exc_pkg::CS_ILLEGAL))
        |-> state_r.exc.vector[19:0] == 20'h00700;
    endproperty
    a_prog_vec: assert property (p_prog_vec) else $error("program vector wrong");

    property p_fpu_vec;
        (acc && !decr_fire && fpu_class && !ctl[`CTL_FLOAT_AVAIL] && win == exc_pkg::CS_FPU_OFF)
        |=> state_r.exc.vector == ($past(base) | 32'h00000800);
    endproperty
    a_fpu_vec: assert property (p_fpu_vec) else $error("float unavailable vector wrong");

    property p_syscall;
        s_syscall |=> state_r.saved_pc_reg == $past(issue.next_pc)
                      && state_r.exc.vector[19:0] == 20'h00C00;
    endproperty
    a_syscall: assert property (p_syscall) else $error("system call dispatch wrong");

    property p_decr_hold;
        (clk_en && state_r.decr_pend && !ctl[`CTL_EXT_INT_EN]) |=> state_r.decr_pend;
    endproperty
    a_decr_hold: assert property (p_decr_hold) else $error("decrementer request lost");

    property p_decr_take;
        (clk_en && decr_fire && !decr_wrap) |=> !state_r.decr_pend && state_r.exc.take
                                               && state_r.exc.vector[19:0] == 20'h00900;
    endproperty
    a_decr_take: assert property (p_decr_take) else $error("decrementer take wrong");

    property p_ser;
        s_ser_start |=> !issue_ready;
    endproperty
    a_ser: assert property (p_ser) else $error("sticky change not serialised");

    property p_emul_keep;
        (acc && !decr_fire && fen_hit && win == exc_pkg::CS_EMUL && !(wr && paddr == `OFF_FSTAT))
        |=> state_r.fsticky == $past(state_r.fsticky) && state_r.exc.vector[19:0] == 20'h01600;
    endproperty
    a_emul_keep: assert property (p_emul_keep) else $error("enabled float condition mishandled");

endmodule

// ### inc/exc_params.svh
// Constants of the exception detect and dispatch block.
// Definitions only; included by the package and the core.
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH

// Register byte offsets on the APB window
`define OFF_CTRL        12'h000
`define OFF_FSTAT       12'h004
`define OFF_DECR        12'h008
`define OFF_FAULT_ADDR  12'h00C
`define OFF_SAVED_PC    12'h010
`define OFF_CAUSE       12'h014

// Machine state control field positions
`define CTL_BYTE_ORDER  0
`define CTL_USER_MODE   1
`define CTL_FLOAT_AVAIL 2
`define CTL_EXT_INT_EN  3
`define CTL_FEM0        4
`define CTL_FEM1        5
`define CTL_NON_IEEE    6
`define CTL_VEC_BASE    7
`define CTL_W           8

// Float status: enables at the bottom, sticky bits above
`define FST_W           5
`define FST_EN_LSB      0
`define FST_STICKY_LSB  8

// Cause register flag positions
`define CAUSE_FPE_FLAG  8
`define CAUSE_PRECISE   9

// Reset values
`define CTL_RST         8'h00
`define FST_RST         5'h00
`define DECR_RST        32'hFFFFFFFF

// Vector bases and handler offsets
`define VBASE_LOW       32'h00000000
`define VBASE_HIGH      32'hFFF00000
`define VOFF_ALIGN      32'h00000600
`define VOFF_PROG       32'h00000700
`define VOFF_FPU        32'h00000800
`define VOFF_DECR       32'h00000900
`define VOFF_SYSCALL    32'h00000C00
`define VOFF_EMUL       32'h00001600

// Bias added to the fault address for multiple transfers
`define MULTI_ADDR_BIAS 32'h00000004

`endif

// ### inc/exc_pkg.sv
// Types of the exception detect and dispatch block.
// Assumes exc_params.svh sits on the include path.
`include "exc_params.svh"

package exc_pkg;

    // Instruction class presented by the decoder
    typedef enum logic [3:0] {
        IC_NONE, IC_LOAD_STORE, IC_FLOAT_LS, IC_FLOAT_ARITH,
        IC_CACHE_ZERO, IC_MULTIPLE, IC_RESERVE, IC_TRAP,
        IC_SYSCALL, IC_SUPERVISOR, IC_BAD_SPECIAL, IC_ILLEGAL,
        IC_WIDE_ONLY, IC_OPT_MISSING, IC_OPT_NOP, IC_EMULATED
    } instr_class_t;

    // Exception taken, reported in the cause register
    typedef enum logic [3:0] {
        CS_NONE, CS_ALIGN, CS_ILLEGAL, CS_PRIV, CS_TRAP,
        CS_FPU_OFF, CS_EMUL, CS_DECR, CS_SYSCALL
    } cause_t;

    // Completion serialisation, Gray along RUN-FIRST-LAST
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FIRST = 2'b01,
        ST_LAST  = 2'b11
    } ser_state_t;

    // One instruction at completion
    typedef struct packed {
        logic                 valid;
        instr_class_t         cls;
        logic [1:0]           size;        // log2 of access bytes
        logic [31:0]          ea;
        logic [31:0]          pc;
        logic [31:0]          next_pc;
        logic                 wt_or_ci;    // Page write-through or inhibited
        logic                 virt;        // Translated data access
        logic                 trap_hit;    // Trap condition true
        logic                 special_bit0;
        logic [`FST_W-1:0]    fp_raised;   // IEEE conditions raised
    } issue_t;

    // Dispatch towards the fetch unit
    typedef struct packed {
        logic        take;
        cause_t      cause;
        logic [31:0] vector;
    } exc_out_t;

    // Whole state of the core
    typedef struct packed {
        logic [`CTL_W-1:0] ctl;
        logic [`FST_W-1:0] fen;
        logic [`FST_W-1:0] fsticky;
        logic [31:0]       decr;
        logic              decr_pend;
        logic [31:0]       fault_address_reg;
        logic [31:0]       saved_pc_reg;
        logic [1:0]        cause_flags;
        exc_out_t          exc;
        ser_state_t        ser;
        logic [31:0]       prdata;
    } state_t;

endpackage

// ### testbench/exc_pipe_model.sv
// Completion-stage model that hands one instruction at a time to the block.
// Assumes the block's clock and its valid/ready acceptance at a rising edge.
`timescale 1ns/1ps
module exc_pipe_model (
    input  wire logic       pclk,
    input  wire logic       issue_ready,
    output exc_pkg::issue_t issue
);
    // Nothing valid at time zero
    initial issue = '0;

    // Hold the word until accepted; then scramble it so stale data never passes
    task automatic send(input exc_pkg::issue_t it);
        @(posedge pclk);
        issue <= it;
        do @(posedge pclk); while (issue_ready !== 1'b1);
        issue <= exc_pkg::issue_t'(~it);
    endtask
endmodule

// ### testbench/exc_detect_dispatch_tb_top.sv
// Self-checking bench for the exception detect and dispatch block.
// Assumes the package, the core and the pipeline model compile first.
`timescale 1ns/1ps
`include "exc_params.svh"
module exc_detect_dispatch_tb_top;
    // One table entry: control, float status, class, size, address, flag, raised, cause, offset
    typedef struct {
        logic [7:0] ctl; logic [4:0] fst; exc_pkg::instr_class_t cls; logic [1:0] sz;
        logic [31:0] ea; logic f; logic [4:0] rz; exc_pkg::cause_t cs; logic [15:0] off;
    } vec_t;
    logic            pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, perr, issue_ready, seen;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata;
    exc_pkg::issue_t issue;
    exc_pkg::exc_out_t exc_event;
    int              errors, checks_done;
    // Flag f drives trap, special bit 0 and the uncached virtual page bits together
    vec_t tv [17] = '{
        '{8'h04, 5'h00, exc_pkg::IC_FLOAT_LS,    2'h2, 32'h102, 1'b0, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h00, 5'h00, exc_pkg::IC_CACHE_ZERO,  2'h2, 32'h100, 1'b1, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h00, 5'h00, exc_pkg::IC_MULTIPLE,    2'h2, 32'h106, 1'b0, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h00, 5'h00, exc_pkg::IC_RESERVE,     2'h2, 32'h101, 1'b0, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h01, 5'h00, exc_pkg::IC_LOAD_STORE,  2'h2, 32'h102, 1'b0, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h01, 5'h00, exc_pkg::IC_MULTIPLE,    2'h2, 32'h100, 1'b0, 5'h00, exc_pkg::CS_ALIGN,   16'h0600},
        '{8'h80, 5'h00, exc_pkg::IC_TRAP,        2'h2, 32'h0,   1'b1, 5'h00, exc_pkg::CS_TRAP,    16'h0700},
        '{8'h00, 5'h00, exc_pkg::IC_TRAP,        2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_NONE,    16'h0000},
        '{8'h00, 5'h00, exc_pkg::IC_ILLEGAL,     2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_ILLEGAL, 16'h0700},
        '{8'h00, 5'h00, exc_pkg::IC_OPT_NOP,     2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_NONE,    16'h0000},
        '{8'h00, 5'h00, exc_pkg::IC_WIDE_ONLY,   2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_ILLEGAL, 16'h0700},
        '{8'h02, 5'h00, exc_pkg::IC_SUPERVISOR,  2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_PRIV,    16'h0700},
        '{8'h00, 5'h00, exc_pkg::IC_EMULATED,    2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_EMUL,    16'h1600},
        '{8'h00, 5'h00, exc_pkg::IC_FLOAT_LS,    2'h2, 32'h102, 1'b0, 5'h00, exc_pkg::CS_FPU_OFF, 16'h0800},
        '{8'h04, 5'h01, exc_pkg::IC_FLOAT_ARITH, 2'h3, 32'h0,   1'b0, 5'h01, exc_pkg::CS_EMUL,    16'h1600},
        '{8'h14, 5'h01, exc_pkg::IC_FLOAT_ARITH, 2'h3, 32'h0,   1'b0, 5'h01, exc_pkg::CS_EMUL,    16'h1600},
        '{8'h80, 5'h00, exc_pkg::IC_SYSCALL,     2'h2, 32'h0,   1'b0, 5'h00, exc_pkg::CS_SYSCALL, 16'h0C00}
    };

    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;

    exc_detect_dispatch dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue(issue), .issue_ready(issue_ready), .exc_event(exc_event));
    exc_pipe_model pipe (.pclk(pclk), .issue_ready(issue_ready), .issue(issue));

    // Count and compare one value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, no latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, e);
    endtask
    // Watch for a take pulse over a bounded number of edges
    task automatic wait_take(input int lim);
        seen = 1'b0;
        // Look at the current cycle first: the pulse may already stand
        for (int n = 0; n < lim && !seen; n++) begin
            #1;
            seen = (exc_event.take === 1'b1);
            if (!seen) begin
                @(posedge pclk);
            end
        end
    endtask
    // Turn a table entry into a completing instruction
    function automatic exc_pkg::issue_t mk(input vec_t v);
        exc_pkg::issue_t it;
        it = '0;
        it.valid = 1'b1;
        it.cls = v.cls;
        it.size = v.sz;
        it.ea = v.ea;
        it.pc = 32'h2000;
        it.next_pc = 32'h2004;
        it.wt_or_ci = v.f;
        it.virt = v.f;
        it.trap_hit = v.f;
        it.special_bit0 = v.f;
        it.fp_raised = v.rz;
        return it;
    endfunction
    // Verdict and end of run, shared with the watchdog
    task automatic complete_run();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far above the expected few hundred cycles
    initial begin
        #200000;
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`OFF_CTRL, 32'h0);
        rdc(12'h040, 32'h0);
        check({31'h0, perr}, 32'h1);
        $display("test reset done");
        foreach (tv[i]) begin
            wr(`OFF_CTRL, {24'h0, tv[i].ctl});
            wr(`OFF_FSTAT, {27'h0, tv[i].fst});
            pipe.send(mk(tv[i]));
            wait_take(3);
            check({31'h0, seen}, {31'h0, tv[i].cs != exc_pkg::CS_NONE});
            if (seen) begin
                check({28'h0, exc_event.cause}, {28'h0, tv[i].cs});
                check(exc_event.vector, (tv[i].ctl[7] ? `VBASE_HIGH : `VBASE_LOW) | tv[i].off);
            end
            if (tv[i].cs == exc_pkg::CS_ALIGN)
                rdc(`OFF_FAULT_ADDR, tv[i].ea + (tv[i].cls == exc_pkg::IC_MULTIPLE ? 32'h4 : 32'h0));
            if (tv[i].cs == exc_pkg::CS_SYSCALL)
                rdc(`OFF_SAVED_PC, 32'h2004);
            if (tv[i].cs == exc_pkg::CS_EMUL && tv[i].fst != 5'h00)
                rdc(`OFF_FSTAT, {27'h0, tv[i].fst});
            $display("test %0d done", i);
        end
        // New sticky bit stalls completion once; a repeat of it does not
        wr(`OFF_CTRL, 32'h4);
        wr(`OFF_FSTAT, 32'h0);
        pipe.send(mk('{8'h04, 5'h00, exc_pkg::IC_FLOAT_ARITH, 2'h3, 32'h0, 1'b0, 5'h02, exc_pkg::CS_NONE, 16'h0}));
        #1;
        check({31'h0, issue_ready}, 32'h0);
        rdc(`OFF_FSTAT, 32'h200);
        pipe.send(mk('{8'h04, 5'h00, exc_pkg::IC_FLOAT_ARITH, 2'h3, 32'h0, 1'b0, 5'h02, exc_pkg::CS_NONE, 16'h0}));
        #1;
        check({31'h0, issue_ready}, 32'h1);
        $display("test serialise done");
        // Decrementer reaches zero before enable; request must be held then taken once
        wr(`OFF_DECR, 32'h4);
        repeat (10) @(posedge pclk);
        wr(`OFF_CTRL, 32'h8);
        wait_take(20);
        check({31'h0, seen}, 32'h1);
        check({28'h0, exc_event.cause}, {28'h0, exc_pkg::CS_DECR});
        check(exc_event.vector, `VBASE_LOW | `VOFF_DECR);
        // Step past the pulse just seen before looking for a second one
        @(posedge pclk);
        wait_take(20);
        check({31'h0, seen}, 32'h0);
        $display("test decrementer done");
        complete_run();
    end
endmodule
